// File: src/xec_error_capture.sv
/*
 * transfer error capture: sticky error flags, per-cause interrupt
 * enables, write-one-to-clear, failing transaction details, and one
 * level error interrupt with a re-evaluation pulse.
 * assumes a synchronous avalon-mm master on clk_i and status buses from
 * the endpoints that are valid for one cycle when nonzero.
 */
// Overview of operation
// (R1) enable bit 3 gates config address error
// (R2) enable bit 2 gates request error
// (R3) enable bit 0 gates bus error
// (R4) software writes zero to enable bit 1
// (R5) clear bit 3 clears config flag only
// (R6) clear bit 2 clears request flag only
// (R7) clear bit 0 clears bus flag, details
// (R8) details bit 17 holds chain option
// (R9) details bit 16 holds irq option
// (R10) details bits 13..8 hold completion code
// (R11) details bits 3..0 hold nonzero status
// (R12) same cycle: record the nonzero status
// (R13) both nonzero: write status wins
// (R14) irq when enabled flag is set
// (R15) bad request sets request error flag
// (R16) bus error sets flag, details readable
// (R17) command bit 0 re-pulses error line
// (R18) details load with bus error flag
// (R19) new error beats same-cycle clear
`timescale 1ns/1ps
`include "xec_map.svh"

module xec_error_capture
    import xec_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // error sources
    input  wire logic        cfg_addr_err_i,
    input  wire logic        req_bad_i,
    input  wire logic [3:0]  rd_status_i,
    input  wire logic [3:0]  wr_status_i,
    input  wire logic        txn_chain_i,
    input  wire logic        txn_irqc_i,
    input  wire logic [5:0]  txn_code_i,
    // interrupt
    output logic             error_irq_o
);

    xec_state_t st_ff;
    xec_state_t nxt_st;

    logic       req;
    logic       wr_acc;
    logic       rd_acc;
    logic [3:0] set_vec;
    logic [3:0] clr_vec;
    logic [3:0] txn_stat;
    logic       be_lo;

    // one wait cycle per access: seen on the first edge, taken on the
    // second, where waitrequest is low; a write lands only there, and
    // read data is snapshotted early so it stands in the answer cycle
    assign req    = (avs_read_i | avs_write_i) & ~st_ff.ack;
    assign wr_acc = avs_write_i & st_ff.ack;
    assign rd_acc = avs_read_i & ~st_ff.ack;
    assign be_lo  = avs_byteenable_i[0];
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_ff.ack;

    // status pick: write beats read, else whichever is nonzero
    always_comb begin
        if (wr_status_i != `XEC_STAT_NONE) begin
            txn_stat = wr_status_i; // R13
        end else begin
            txn_stat = rd_status_i; // R12
        end
    end

    // hardware set and software clear vectors
    always_comb begin
        set_vec = `XEC_RST_FLAGS;
        set_vec[`XEC_BIT_CFG] = cfg_addr_err_i;
        set_vec[`XEC_BIT_REQ] = req_bad_i; // R15
        set_vec[`XEC_BIT_BUS] = (txn_stat != `XEC_STAT_NONE); // R16
        clr_vec = `XEC_RST_FLAGS;
        if (wr_acc && be_lo && avs_address_i == `XEC_ADDR_CLEAR) begin
            // R5 R6 R7
            clr_vec = avs_writedata_i[`XEC_FLAG_W-1:0];
            clr_vec[`XEC_BIT_RSVD] = 1'b0;
        end
    end

    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        nxt_st.pulse_gap = 1'b0;
        // set wins over clear
        nxt_st.flags = (st_ff.flags & ~clr_vec) | set_vec; // R19
        // details: bus clear wipes, a new status capture overrides it
        if (clr_vec[`XEC_BIT_BUS]) begin
            nxt_st.details = `XEC_RST_DETAILS; // R7
        end
        if (set_vec[`XEC_BIT_BUS]) begin
            nxt_st.details = `XEC_ZERO32; // R18
            nxt_st.details[`XEC_DET_CHAIN] = txn_chain_i; // R8
            nxt_st.details[`XEC_DET_IRQC] = txn_irqc_i; // R9
            nxt_st.details[`XEC_DET_CODE_HI:`XEC_DET_CODE_LO]
                = txn_code_i; // R10
            nxt_st.details[`XEC_DET_STAT_HI:`XEC_DET_STAT_LO]
                = txn_stat; // R11
        end
        // register writes; bit 1 of enable is kept as written, unused
        if (wr_acc && be_lo) begin
            if (avs_address_i == `XEC_ADDR_ENABLE) begin
                nxt_st.enable = avs_writedata_i[`XEC_FLAG_W-1:0]; // R4
            end else if (avs_address_i == `XEC_ADDR_COMMAND) begin
                // low gap so an edge-sensitive sink sees a new pulse
                nxt_st.pulse_gap = avs_writedata_i[`XEC_CMD_REEVAL]; // R17
            end
        end
        // reads, registered for the answer cycle
        nxt_st.rdata = `XEC_ZERO32;
        if (rd_acc) begin
            if (avs_address_i == `XEC_ADDR_STATUS) begin
                nxt_st.rdata[`XEC_FLAG_W-1:0] = st_ff.flags;
            end else if (avs_address_i == `XEC_ADDR_ENABLE) begin
                nxt_st.rdata[`XEC_FLAG_W-1:0] = st_ff.enable;
            end else if (avs_address_i == `XEC_ADDR_DETAILS) begin
                nxt_st.rdata = st_ff.details;
            end else begin
                nxt_st.rdata = `XEC_ZERO32; // clear, command, unmapped
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata_o = st_ff.rdata;

    // masked or of flags; reserved bit 1 never contributes
    assign error_irq_o = ~st_ff.pulse_gap & ( // R14
        (st_ff.flags[`XEC_BIT_CFG] & st_ff.enable[`XEC_BIT_CFG])   // R1
      | (st_ff.flags[`XEC_BIT_REQ] & st_ff.enable[`XEC_BIT_REQ])   // R2
      | (st_ff.flags[`XEC_BIT_BUS] & st_ff.enable[`XEC_BIT_BUS])); // R3

    // assertions: each enabled cause drives the line, disabled ones do not
    cfg_gate_a: assert property ( // R1
        @(posedge clk_i) disable iff (reset_i)
        (!st_ff.pulse_gap && st_ff.flags[`XEC_BIT_CFG]
            && st_ff.enable[`XEC_BIT_CFG]) |-> error_irq_o)
        else $error("config error not driving irq");

    req_gate_a: assert property ( // R2
        @(posedge clk_i) disable iff (reset_i)
        (st_ff.flags[`XEC_BIT_REQ] && st_ff.enable[`XEC_BIT_REQ]
            && !st_ff.pulse_gap) |-> error_irq_o)
        else $error("request error not driving irq");

    bus_drive_a: assert property ( // R3
        @(posedge clk_i) disable iff (reset_i)
        (st_ff.flags[`XEC_BIT_BUS] && st_ff.enable[`XEC_BIT_BUS]
            && !st_ff.pulse_gap) |-> error_irq_o)
        else $error("bus error not driving irq");

    bus_gate_a: assert property ( // R3
        @(posedge clk_i) disable iff (reset_i)
        (error_irq_o && !(st_ff.flags[`XEC_BIT_BUS]
            && st_ff.enable[`XEC_BIT_BUS]))
            |-> (st_ff.flags & st_ff.enable & `XEC_FLAG_HI)
                != `XEC_RST_FLAGS)
        else $error("irq without an enabled flag");

    // the reserved enable bit alone never raises the line
    irq_low_a: assert property ( // R14
        @(posedge clk_i) disable iff (reset_i)
        ((st_ff.flags & st_ff.enable & `XEC_FLAG_USED) == `XEC_RST_FLAGS)
            |-> !error_irq_o)
        else $error("irq high with no enabled flag");

    // clears: config and request keep the details, bus wipes them
    cfg_clear_a: assert property ( // R5
        @(posedge clk_i) disable iff (reset_i)
        (wr_acc && be_lo && avs_address_i == `XEC_ADDR_CLEAR
            && avs_writedata_i[`XEC_BIT_CFG] && !cfg_addr_err_i
            && !avs_writedata_i[`XEC_BIT_BUS]
            && txn_stat == `XEC_STAT_NONE)
            |=> !st_ff.flags[`XEC_BIT_CFG] && $stable(st_ff.details))
        else $error("config clear failed");

    req_clear_a: assert property ( // R6
        @(posedge clk_i) disable iff (reset_i)
        (wr_acc && be_lo && avs_address_i == `XEC_ADDR_CLEAR
            && avs_writedata_i[`XEC_BIT_REQ] && !req_bad_i)
            |=> !st_ff.flags[`XEC_BIT_REQ])
        else $error("request clear failed");

    req_keep_a: assert property ( // R6
        @(posedge clk_i) disable iff (reset_i)
        (wr_acc && be_lo && avs_address_i == `XEC_ADDR_CLEAR
            && avs_writedata_i[`XEC_BIT_REQ]
            && !avs_writedata_i[`XEC_BIT_BUS]
            && txn_stat == `XEC_STAT_NONE)
            |=> $stable(st_ff.details))
        else $error("request clear touched details");

    bus_clear_a: assert property ( // R7
        @(posedge clk_i) disable iff (reset_i)
        (wr_acc && be_lo && avs_address_i == `XEC_ADDR_CLEAR
            && avs_writedata_i[`XEC_BIT_BUS]
            && txn_stat == `XEC_STAT_NONE)
            |=> !st_ff.flags[`XEC_BIT_BUS]
                && st_ff.details == `XEC_RST_DETAILS)
        else $error("bus clear failed");

    zero_clear_a: assert property ( // R5
        @(posedge clk_i) disable iff (reset_i)
        (wr_acc && be_lo && avs_address_i == `XEC_ADDR_CLEAR
            && avs_writedata_i[`XEC_FLAG_W-1:0] == `XEC_RST_FLAGS)
            |=> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags))
        else $error("zero clear dropped a flag");

    // capture of the failing transaction
    detail_load_a: assert property ( // R11
        @(posedge clk_i) disable iff (reset_i)
        (txn_stat != `XEC_STAT_NONE) |=> st_ff.flags[`XEC_BIT_BUS]
            && st_ff.details[`XEC_DET_STAT_HI:`XEC_DET_STAT_LO]
                == $past(txn_stat)
            && st_ff.details[`XEC_DET_CODE_HI:`XEC_DET_CODE_LO]
                == $past(txn_code_i)
            && st_ff.details[`XEC_DET_CHAIN] == $past(txn_chain_i))
        else $error("details not captured");

    opt_load_a: assert property ( // R8 R9
        @(posedge clk_i) disable iff (reset_i)
        (txn_stat != `XEC_STAT_NONE)
            |=> st_ff.details[`XEC_DET_CHAIN] == $past(txn_chain_i)
            && st_ff.details[`XEC_DET_IRQC] == $past(txn_irqc_i))
        else $error("completion options not captured");

    code_load_a: assert property ( // R10
        @(posedge clk_i) disable iff (reset_i)
        (txn_stat != `XEC_STAT_NONE)
            |=> st_ff.details[`XEC_DET_CODE_HI:`XEC_DET_CODE_LO]
                == $past(txn_code_i))
        else $error("completion code not captured");

    rd_pick_a: assert property ( // R12
        @(posedge clk_i) disable iff (reset_i)
        (wr_status_i == `XEC_STAT_NONE && rd_status_i != `XEC_STAT_NONE)
            |=> st_ff.details[`XEC_DET_STAT_HI:`XEC_DET_STAT_LO]
                == $past(rd_status_i))
        else $error("read status not recorded");

    wr_prio_a: assert property ( // R13
        @(posedge clk_i) disable iff (reset_i)
        (wr_status_i != `XEC_STAT_NONE)
            |=> st_ff.details[`XEC_DET_STAT_HI:`XEC_DET_STAT_LO]
                == $past(wr_status_i))
        else $error("write status lost priority");

    rsvd_zero_a: assert property ( // R18
        @(posedge clk_i) disable iff (reset_i)
        (st_ff.details & ~`XEC_DET_USED) == `XEC_ZERO32)
        else $error("reserved details bit set");

    // hardware sets win over a clear in the same cycle
    bus_set_a: assert property ( // R16
        @(posedge clk_i) disable iff (reset_i)
        (rd_status_i != `XEC_STAT_NONE || wr_status_i != `XEC_STAT_NONE)
            |=> st_ff.flags[`XEC_BIT_BUS])
        else $error("bus error flag not set");

    set_wins_a: assert property ( // R19
        @(posedge clk_i) disable iff (reset_i)
        req_bad_i |=> st_ff.flags[`XEC_BIT_REQ])
        else $error("request error lost to clear");

    // re-evaluation: one low cycle, then the level returns
    reeval_a: assert property ( // R17
        @(posedge clk_i) disable iff (reset_i)
        (wr_acc && be_lo && avs_address_i == `XEC_ADDR_COMMAND
            && avs_writedata_i[`XEC_CMD_REEVAL]
            && (st_ff.flags & st_ff.enable & `XEC_FLAG_USED)
                != `XEC_RST_FLAGS)
            |=> !error_irq_o ##1 error_irq_o)
        else $error("re-evaluation pulse missing");

    gap_once_a: assert property ( // R17
        @(posedge clk_i) disable iff (reset_i)
        st_ff.pulse_gap |=> !st_ff.pulse_gap)
        else $error("re-evaluation gap too long");

    // bus answer: one wait cycle, read data only in the answer cycle
    wait_once_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ((avs_read_i || avs_write_i) && avs_waitrequest_o)
            |=> !avs_waitrequest_o)
        else $error("request waited more than one cycle");

    rdata_idle_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !(avs_read_i && !avs_waitrequest_o)
            |-> avs_readdata_o == `XEC_ZERO32)
        else $error("read data outside the answer cycle");

    unmap_read_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (avs_read_i && avs_waitrequest_o
            && (avs_address_i == `XEC_ADDR_CLEAR
            || avs_address_i == `XEC_ADDR_COMMAND
            || avs_address_i == `XEC_ADDR_CFGERR))
            |=> avs_readdata_o == `XEC_ZERO32)
        else $error("write-only or unused word read nonzero");

endmodule

// File: src/xec_map.svh
/*
 * register offsets, field positions and reset values of the transfer
 * error capture block.
 * assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
 */
`ifndef XEC_MAP_SVH
`define XEC_MAP_SVH

// byte addresses (word index times four)
`define XEC_ADDR_STATUS   6'h00
`define XEC_ADDR_ENABLE   6'h04
`define XEC_ADDR_CLEAR    6'h08
`define XEC_ADDR_DETAILS  6'h0c
`define XEC_ADDR_COMMAND  6'h10
`define XEC_ADDR_CFGERR   6'h14

// error flag bit positions, shared by status, enable and clear
`define XEC_BIT_CFG       3
`define XEC_BIT_REQ       2
`define XEC_BIT_RSVD      1
`define XEC_BIT_BUS       0
`define XEC_FLAG_W        4
// flags that may raise the line, and the two upper causes alone
`define XEC_FLAG_USED     4'hd
`define XEC_FLAG_HI       4'hc

// details field positions
`define XEC_DET_CHAIN     17
`define XEC_DET_IRQC      16
`define XEC_DET_CODE_HI   13
`define XEC_DET_CODE_LO   8
`define XEC_DET_STAT_HI   3
`define XEC_DET_STAT_LO   0
// every details bit that is not reserved
`define XEC_DET_USED      32'h0003_3f0f

// command bit
`define XEC_CMD_REEVAL    0

// reset values
`define XEC_RST_FLAGS     4'h0
`define XEC_RST_DETAILS   32'h0000_0000
`define XEC_STAT_NONE     4'h0
`define XEC_ZERO32        32'h0000_0000

`endif

// File: src/xec_pkg.sv
/*
 * types of the transfer error capture block.
 * assumes the constants of xec_map.svh for field positions.
 */
package xec_pkg;

    // state of the block, registered as one struct
    typedef struct packed {
        logic [3:0]  flags;      // sticky error status
        logic [3:0]  enable;     // interrupt enable per cause
        logic [31:0] details;    // captured failing transaction
        logic        pulse_gap;  // forces irq low for one cycle
        logic        ack;        // bus answer cycle
        logic [31:0] rdata;
    } xec_state_t;

endpackage

// File: verif/testbench.sv
/* self-checking bench of the error capture block.
   assumes the endpoint model and the register map header. */
`timescale 1ns/1ps
`include "xec_map.svh"
module testbench;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [5:0]  addr = 6'h00;
    logic        rd = 1'b0, wr = 1'b0, fire = 1'b0, cfg = 1'b0, req = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        waitreq, irq;
    logic [3:0]  rc = 4'h0, wc = 4'h0, rs, ws, st;
    logic [7:0]  options_word = 8'h00, topt;
    logic [31:0] exp_q[$];
    logic [7:0]  pairs[3] = '{8'h50, 8'h09, 8'h6c};
    int          cause[3] = '{3, 2, 0};
    int          mismatches = 0, check_count = 0;

    xec_error_capture dut_u (.clk_i(clk_i), .reset_i(reset_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .cfg_addr_err_i(cfg), .req_bad_i(req), .rd_status_i(rs),
        .wr_status_i(ws), .txn_chain_i(topt[7]), .txn_irqc_i(topt[6]),
        .txn_code_i(topt[5:0]), .error_irq_o(irq));
    xec_endpoint_model ep_u (.clk_i(clk_i), .fire_i(fire),
        .rd_code_i(rc), .wr_code_i(wc), .opt_i(options_word),
        .rd_status_o(rs), .wr_status_o(ws), .opt_o(topt));

    // 50 ns clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] e, logic [31:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask

    // waitrequest sampled at each rising edge; released only after the
    // edge at which it is seen low
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (waitreq !== 1'b0) begin
            check("ack", 32'h0, 32'h1);
            conclude();
        end else begin
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask

    task automatic bus_wr(logic [5:0] a, logic [31:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        wait_ack();
    endtask

    task automatic bus_rd(logic [5:0] a, logic [31:0] e);
        @(posedge clk_i);
        exp_q.push_back(e);
        addr <= a;
        rd   <= 1'b1;
        wait_ack();
    endtask

    task automatic chk_irq(logic e);
        @(negedge clk_i);
        check("irq", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic bus_err(logic [3:0] r, logic [3:0] w);
        @(posedge clk_i);
        rc   <= r;
        wc   <= w;
        options_word  <= 8'($urandom);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic raise(int k);
        if (k == 0) begin
            bus_err(4'h3, 4'h0);
        end else begin
            @(posedge clk_i);
            cfg <= (k == 3);
            req <= (k == 2);
            @(posedge clk_i);
            cfg <= 1'b0;
            req <= 1'b0;
        end
    endtask

    function automatic logic [31:0] det(logic [3:0] s);
        return {14'h0, options_word[7:6], 2'h0, options_word[5:0], 4'h0, s};
    endfunction

    // read data taken at the rising edge where waitrequest is low
    always @(posedge clk_i) begin
        if (rd === 1'b1 && waitreq === 1'b0) begin
            check("readdata", exp_q.pop_front(), rdata);
        end
    end

    initial begin
        void'($urandom(32'h59f4b371));
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        bus_rd(`XEC_ADDR_STATUS, 32'h0);
        bus_rd(`XEC_ADDR_ENABLE, 32'h0);
        bus_rd(`XEC_ADDR_DETAILS, 32'h0);
        bus_rd(`XEC_ADDR_CFGERR, 32'h0);
        $display("test reset values done");
        // read only, write only and both statuses in one cycle
        foreach (pairs[i]) begin
            bus_err(pairs[i][7:4], pairs[i][3:0]);
            st = (pairs[i][3:0] != 4'h0) ? pairs[i][3:0] : pairs[i][7:4];
            bus_rd(`XEC_ADDR_DETAILS, det(st));
        end
        $display("test details capture done");
        // each cause masked, enabled, cleared with zero, cleared with one
        foreach (cause[i]) begin
            bus_wr(`XEC_ADDR_ENABLE, 32'h0);
            raise(cause[i]);
            chk_irq(1'b0);
            bus_wr(`XEC_ADDR_ENABLE, 32'h1 << cause[i]);
            chk_irq(1'b1);
            bus_rd(`XEC_ADDR_STATUS, (32'h1 << cause[i]) | 32'h1);
            bus_wr(`XEC_ADDR_CLEAR, 32'h0);
            chk_irq(1'b1);
            bus_wr(`XEC_ADDR_CLEAR, 32'h1 << cause[i]);
            chk_irq(1'b0);
            bus_rd(`XEC_ADDR_DETAILS, cause[i] == 0 ? 32'h0 : det(st));
        end
        $display("test enables and clears done");
        bus_err(4'h0, 4'h8);
        bus_wr(`XEC_ADDR_ENABLE, 32'h1);
        bus_wr(`XEC_ADDR_COMMAND, 32'h1);
        chk_irq(1'b0);
        chk_irq(1'b1);
        $display("test re-evaluation done");
        conclude();
    end
endmodule

// File: verif/xec_endpoint_model.sv
/* endpoint model: one-cycle read and write status with options.
   assumes fire_i is driven just after rising edges of clk_i. */
`timescale 1ns/1ps
module xec_endpoint_model (
    input  wire logic       clk_i,
    input  wire logic       fire_i,
    input  wire logic [3:0] rd_code_i,
    input  wire logic [3:0] wr_code_i,
    input  wire logic [7:0] opt_i,
    output logic      [3:0] rd_status_o,
    output logic      [3:0] wr_status_o,
    output logic      [7:0] opt_o
);
    logic [7:0] opt_ff = 8'h00;
    // status lives one cycle; idle options toggle so stale ones never
    // pass for valid
    always @(posedge clk_i) begin
        rd_status_o <= fire_i ? rd_code_i : 4'h0;
        wr_status_o <= fire_i ? wr_code_i : 4'h0;
        opt_ff      <= fire_i ? opt_i : ~opt_ff;
    end
    assign opt_o = opt_ff;
endmodule
